//--- rtl/dcp_byte_lane.sv
// One byte lane: read-side inversion encoding and write-side unmask or decode.
`timescale 1ns/10ps
module dcp_byte_lane (
    input  wire logic [7:0] i_rd_raw,
    input  wire logic       i_inv_en,
    input  wire logic       i_mask_mode,
    input  wire logic [7:0] i_wr_pin,
    input  wire logic       i_wr_flag,
    output logic      [7:0] o_rd_pin,
    output logic            o_rd_flag,
    output logic      [7:0] o_wr_byte,
    output logic            o_wr_mask
);
    logic [3:0] ones;

    always_comb begin
        ones = 4'h0;
        for (int b = 0; b < 8; b++) begin
            ones = ones + {3'h0, i_rd_raw[b]};
        end
        // Inverting a byte with more than four ones keeps at most four of its lines high.
        o_rd_flag = i_inv_en && !i_mask_mode && (ones > 4'h4);
        o_rd_pin  = i_rd_raw ^ {8{o_rd_flag}};
        if (i_mask_mode) begin
            o_wr_byte = i_wr_pin;
            o_wr_mask = i_wr_flag;
        end else begin
            o_wr_byte = i_wr_pin ^ {8{i_inv_en && i_wr_flag}};
            o_wr_mask = 1'b0;
        end
    end
endmodule // dcp_byte_lane

//--- rtl/dcp_channel.sv
// Pin-side logic of one DRAM channel: command capture, read bursts and write capture.
`timescale 1ns/10ps
module dcp_channel (
    input  wire logic                                  i_mclk,
    input  wire logic                                  i_sys_rst,
    input  wire logic                                  i_reset_pin_n,
    input  wire logic                                  i_clock_true,
    input  wire logic                                  i_clock_complement,
    input  wire logic                                  i_clock_gate,
    input  wire logic                                  i_chip_select,
    input  wire logic [dcp_pkg::CA_W-1:0]              i_command_address_bus,
    input  wire logic                                  i_cmd_termination_pin,
    input  wire logic                                  i_scan_enable,
    input  wire logic [dcp_pkg::CFG_W-1:0]             i_termination_mode_cfg,
    input  wire logic [dcp_pkg::CFG_W-1:0]             i_termination_mode_cfg_ext,
    input  wire logic                                  i_inversion_en,
    input  wire logic                                  i_mask_mode,
    input  wire logic [dcp_pkg::PREFETCH-1:0]          i_array_rd_data,
    input  wire logic [dcp_pkg::DQ_W-1:0]              i_dq,
    output logic      [dcp_pkg::DQ_W-1:0]              o_dq,
    output logic                                       o_dq_oe,
    input  wire logic [dcp_pkg::LANES-1:0]             i_dqs_t,
    input  wire logic [dcp_pkg::LANES-1:0]             i_dqs_c,
    output logic      [dcp_pkg::LANES-1:0]             o_dqs_t,
    output logic      [dcp_pkg::LANES-1:0]             o_dqs_c,
    output logic                                       o_dqs_oe,
    input  wire logic [dcp_pkg::LANES-1:0]             i_mask_invert_line,
    output logic      [dcp_pkg::LANES-1:0]             o_mask_invert_line,
    output logic                                       o_mask_invert_oe,
    output logic                                       o_cmd_valid,
    output logic      [1:0]                            o_cmd_op,
    output logic      [dcp_pkg::BANK_W-1:0]            o_bank_select_bits,
    output logic      [dcp_pkg::ROW_W-1:0]             o_row_select_bits,
    output logic      [dcp_pkg::COL_W-1:0]             o_column_select_bits,
    output logic                                       o_wr_valid,
    output logic      [dcp_pkg::PREFETCH-1:0]          o_wr_data,
    output logic      [dcp_pkg::MASK_W-1:0]            o_wr_mask,
    output logic      [dcp_pkg::TERM_CA_W-1:0]         o_ca_term_code,
    output logic                                       o_cs_term_en,
    output logic                                       o_ck_term_en,
    output logic                                       o_scan_active
);
    typedef struct packed {
        logic                                 ckt_s1;
        logic                                 ckt_s2;
        logic                                 ckt_p;
        logic                                 ckc_s1;
        logic                                 ckc_s2;
        logic                                 cke_s1;
        logic                                 cke_s2;
        logic                                 cs_s1;
        logic                                 cs_s2;
        logic [dcp_pkg::CA_W-1:0]             ca_s1;
        logic [dcp_pkg::CA_W-1:0]             ca_s2;
        logic                                 rstn_s1;
        logic                                 rstn_s2;
        logic                                 scan_s1;
        logic                                 scan_s2;
        logic [dcp_pkg::LANES-1:0]            dqs_s1;
        logic [dcp_pkg::LANES-1:0]            dqs_s2;
        logic [dcp_pkg::LANES-1:0]            dqs_p;
        logic [dcp_pkg::DQ_W-1:0]             dq_s1;
        logic [dcp_pkg::DQ_W-1:0]             dq_s2;
        logic [dcp_pkg::LANES-1:0]            mli_s1;
        logic [dcp_pkg::LANES-1:0]            mli_s2;
        dcp_pkg::dcp_state_type               state;
        logic                                 collecting;
        logic [1:0]                           slot_cnt;
        logic [dcp_pkg::HOLD_W-1:0]           cmd_word;
        logic                                 cmd_valid;
        logic [1:0]                           cmd_op;
        logic [dcp_pkg::BANK_W-1:0]           bank;
        logic [dcp_pkg::ROW_W-1:0]            row;
        logic [dcp_pkg::COL_W-1:0]            col;
        logic [dcp_pkg::PREFETCH-1:0]         rd_buf;
        logic [dcp_pkg::BEAT_W-1:0]           beat;
        logic [dcp_pkg::TICK_W-1:0]           tick;
        logic [dcp_pkg::DQ_W-1:0]             dq_out;
        logic                                 dq_oe;
        logic [dcp_pkg::LANES-1:0]            dqs_t_out;
        logic [dcp_pkg::LANES-1:0]            dqs_c_out;
        logic                                 dqs_oe;
        logic [dcp_pkg::LANES-1:0]            mli_out;
        logic                                 mli_oe;
        logic [dcp_pkg::LANES-1:0][dcp_pkg::BEAT_W-1:0] wr_cnt;
        logic [dcp_pkg::PREFETCH-1:0]         wr_data;
        logic [dcp_pkg::MASK_W-1:0]           wr_mask;
        logic                                 wr_valid;
        logic [dcp_pkg::TERM_CA_W-1:0]        term_ca;
        logic                                 term_cs;
        logic                                 term_ck;
    } dcp_chan_type;

    dcp_chan_type q;
    dcp_chan_type d;

    logic [dcp_pkg::DQ_W-1:0]   rd_raw;
    logic [dcp_pkg::DQ_W-1:0]   rd_enc;
    logic [dcp_pkg::LANES-1:0]  rd_flag;
    logic [dcp_pkg::DQ_W-1:0]   wr_dec;
    logic [dcp_pkg::LANES-1:0]  wr_msk;
    logic [dcp_pkg::WORD_W-1:0] word;
    logic                       link_edge;

    // Each lane is encoded and decoded on its own, so lanes never share a flag.
    assign rd_raw = q.rd_buf[{q.beat[3:0], 4'h0} +: dcp_pkg::DQ_W];
    for (genvar l = 0; l < dcp_pkg::LANES; l++) begin : g_lane
        dcp_byte_lane u_lane (
            .i_rd_raw    (rd_raw[l*8 +: 8]),
            .i_inv_en    (i_inversion_en),
            .i_mask_mode (i_mask_mode),
            .i_wr_pin    (q.dq_s2[l*8 +: 8]),
            .i_wr_flag   (q.mli_s2[l]),
            .o_rd_pin    (rd_enc[l*8 +: 8]),
            .o_rd_flag   (rd_flag[l]),
            .o_wr_byte   (wr_dec[l*8 +: 8]),
            .o_wr_mask   (wr_msk[l])
        );
    end

    // Sampling the differential pair avoids false edges while only one leg has moved.
    assign link_edge = q.ckt_s2 && !q.ckt_p && !q.ckc_s2;
    assign word      = {q.cmd_word, q.ca_s2};

    always_comb begin
        logic [7:0] widx;
        widx = 8'h00;
        d = q;
        d.ckt_s1  = i_clock_true;
        d.ckt_s2  = q.ckt_s1;
        d.ckt_p   = q.ckt_s2;
        d.ckc_s1  = i_clock_complement;
        d.ckc_s2  = q.ckc_s1;
        d.cke_s1  = i_clock_gate;
        d.cke_s2  = q.cke_s1;
        d.cs_s1   = i_chip_select;
        d.cs_s2   = q.cs_s1;
        d.ca_s1   = i_command_address_bus;
        d.ca_s2   = q.ca_s1;
        d.rstn_s1 = i_reset_pin_n;
        d.rstn_s2 = q.rstn_s1;
        d.scan_s1 = i_scan_enable;
        d.scan_s2 = q.scan_s1;
        d.dqs_s1  = i_dqs_t;
        d.dqs_s2  = q.dqs_s1;
        d.dqs_p   = q.dqs_s2;
        d.dq_s1   = i_dq;
        d.dq_s2   = q.dq_s1;
        d.mli_s1  = i_mask_invert_line;
        d.mli_s2  = q.mli_s1;
        // The termination pin is never read; only the two configs steer it.
        d.term_ca = i_termination_mode_cfg[dcp_pkg::TERM_CA_LSB +: dcp_pkg::TERM_CA_W];
        d.term_cs = i_termination_mode_cfg_ext[dcp_pkg::EXT_CS_BIT];
        d.term_ck = i_termination_mode_cfg_ext[dcp_pkg::EXT_CK_BIT];
        d.cmd_valid = 1'b0;
        d.wr_valid  = 1'b0;

        // Command capture: a chip-select sample opens four command bus samples.
        if (link_edge && q.cke_s2) begin
            if (!q.collecting) begin
                if (q.cs_s2) begin
                    d.collecting = 1'b1;
                    d.slot_cnt   = 2'h1;
                    d.cmd_word   = {q.cmd_word[dcp_pkg::HOLD_W-dcp_pkg::CA_W-1:0], q.ca_s2};
                end
            end else if (q.slot_cnt != dcp_pkg::SLOT_LAST) begin
                d.slot_cnt = q.slot_cnt + 2'h1;
                d.cmd_word = {q.cmd_word[dcp_pkg::HOLD_W-dcp_pkg::CA_W-1:0], q.ca_s2};
            end else begin
                d.collecting = 1'b0;
                d.slot_cnt   = 2'h0;
                d.cmd_op     = word[dcp_pkg::OP_LSB +: 2];
                d.cmd_valid  = (d.cmd_op != dcp_pkg::OP_NOP);
                d.bank       = word[dcp_pkg::BANK_LSB +: dcp_pkg::BANK_W];
                if (d.cmd_op == dcp_pkg::OP_ACT) begin
                    d.row = word[dcp_pkg::ROW_LSB +: dcp_pkg::ROW_W];
                end else if (d.cmd_valid) begin
                    // The two low column bits are not carried, so bursts start aligned.
                    d.col = {word[dcp_pkg::COLHI_LSB +: dcp_pkg::COL_W-dcp_pkg::COL_ZERO],
                             dcp_pkg::COL_ZERO'(0)};
                    if (q.state == dcp_pkg::ST_IDLE && d.cmd_op == dcp_pkg::OP_RD) begin
                        d.state = dcp_pkg::ST_RD_LOAD;
                    end else if (q.state == dcp_pkg::ST_IDLE) begin
                        d.state  = dcp_pkg::ST_WR_CAPT;
                        d.wr_cnt = '0;
                    end
                end
            end
        end

        case (q.state)
            dcp_pkg::ST_IDLE: begin
                d.dq_oe  = 1'b0;
                d.dqs_oe = 1'b0;
                d.mli_oe = 1'b0;
            end
            dcp_pkg::ST_RD_LOAD: begin
                d.rd_buf = i_array_rd_data;
                d.beat   = 5'h00;
                d.tick   = dcp_pkg::TICK_RST;
                d.state  = dcp_pkg::ST_RD_BURST;
            end
            dcp_pkg::ST_RD_BURST: begin
                if (q.tick != dcp_pkg::TICK_RST) begin
                    d.tick = q.tick - 3'h1;
                end else if (q.beat == 5'(dcp_pkg::BEATS)) begin
                    d.state  = dcp_pkg::ST_IDLE;
                    d.dq_oe  = 1'b0;
                    d.dqs_oe = 1'b0;
                    d.mli_oe = 1'b0;
                end else begin
                    // Strobe and data change on the same edge: edge aligned.
                    d.dq_out    = rd_enc;
                    d.mli_out   = rd_flag;
                    d.dqs_t_out = {dcp_pkg::LANES{~q.beat[0]}};
                    d.dqs_c_out = {dcp_pkg::LANES{q.beat[0]}};
                    d.dq_oe     = 1'b1;
                    d.dqs_oe    = 1'b1;
                    d.mli_oe    = 1'b1;
                    d.tick      = dcp_pkg::BEAT_TOP;
                    d.beat      = q.beat + 5'h01;
                end
            end
            dcp_pkg::ST_WR_CAPT: begin
                // Each lane counts beats on its own strobe; the controller drives them.
                for (int l = 0; l < dcp_pkg::LANES; l++) begin
                    if (q.dqs_s2[l] != q.dqs_p[l] && q.wr_cnt[l] != 5'(dcp_pkg::BEATS)) begin
                        widx = {q.wr_cnt[l][3:0], l[0], 3'h0};
                        d.wr_data[widx +: 8] = wr_dec[l*8 +: 8];
                        d.wr_mask[widx[7:3]] = wr_msk[l];
                        d.wr_cnt[l] = q.wr_cnt[l] + 5'h01;
                    end
                end
                if (q.wr_cnt[0] == 5'(dcp_pkg::BEATS) && q.wr_cnt[1] == 5'(dcp_pkg::BEATS)) begin
                    d.wr_valid = 1'b1;
                    d.state    = dcp_pkg::ST_IDLE;
                end
            end
            default: begin
                d.state = dcp_pkg::ST_IDLE;
            end
        endcase

        // A low clock gate stops capture and turns the drivers off at once.
        if (!q.cke_s2) begin
            d.collecting = 1'b0;
            d.slot_cnt   = 2'h0;
            d.state      = dcp_pkg::ST_IDLE;
            d.dq_oe      = 1'b0;
            d.dqs_oe     = 1'b0;
            d.mli_oe     = 1'b0;
        end
        // The die reset pin clears capture, state, drivers and beat counters but keeps addresses and data.
        if (!q.rstn_s2) begin
            d.collecting = 1'b0;
            d.slot_cnt   = 2'h0;
            d.state      = dcp_pkg::ST_IDLE;
            d.dq_oe      = 1'b0;
            d.dqs_oe     = 1'b0;
            d.mli_oe     = 1'b0;
            d.cmd_valid  = 1'b0;
            d.wr_valid   = 1'b0;
            d.wr_cnt     = '0;
            d.beat       = 5'h00;
            d.tick       = dcp_pkg::TICK_RST;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_dq                 = q.dq_out;
    assign o_dq_oe              = q.dq_oe;
    assign o_dqs_t              = q.dqs_t_out;
    assign o_dqs_c              = q.dqs_c_out;
    assign o_dqs_oe             = q.dqs_oe;
    assign o_mask_invert_line   = q.mli_out;
    assign o_mask_invert_oe     = q.mli_oe;
    assign o_cmd_valid          = q.cmd_valid;
    assign o_cmd_op             = q.cmd_op;
    assign o_bank_select_bits   = q.bank;
    assign o_row_select_bits    = q.row;
    assign o_column_select_bits = q.col;
    assign o_wr_valid           = q.wr_valid;
    assign o_wr_data            = q.wr_data;
    assign o_wr_mask            = q.wr_mask;
    assign o_ca_term_code       = q.term_ca;
    assign o_cs_term_en         = q.term_cs;
    assign o_ck_term_en         = q.term_ck;
    assign o_scan_active        = q.scan_s2;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    logic beat_start;
    assign beat_start = q.dq_oe && (q.tick == dcp_pkg::BEAT_TOP);

    property p_term_from_cfg;
        ##1 o_ca_term_code == $past(i_termination_mode_cfg[dcp_pkg::TERM_CA_LSB +: dcp_pkg::TERM_CA_W]);
    endproperty
    a_term_from_cfg: assert property (p_term_from_cfg) else $error("termination code not from config");

    property p_rd_strobe_aligned;
        (q.dq_oe && $past(q.dq_oe) && $changed(q.dq_out)) |-> $changed(q.dqs_t_out);
    endproperty
    a_rd_strobe_aligned: assert property (p_rd_strobe_aligned) else $error("read data moved without strobe");

    property p_strobe_pair;
        q.dqs_oe |-> (q.dqs_c_out == ~q.dqs_t_out);
    endproperty
    a_strobe_pair: assert property (p_strobe_pair) else $error("strobe legs not complementary");

    property p_inv_flag;
        beat_start |-> ((q.mli_out[0] && $countones(q.dq_out[7:0]) < 4)
                        || (!q.mli_out[0] && $countones(q.dq_out[7:0]) <= 4) || !$past(i_inversion_en)
                        || $past(i_mask_mode));
    endproperty
    a_inv_flag: assert property (p_inv_flag) else $error("inversion flag disagrees with byte");

    property p_inv_off;
        (beat_start && !$past(i_inversion_en)) |-> (q.mli_out == 2'h0);
    endproperty
    a_inv_off: assert property (p_inv_off) else $error("inverted byte while inversion off");

    property p_mask_mode_rd;
        (beat_start && $past(i_mask_mode)) |-> (q.mli_out == 2'h0);
    endproperty
    a_mask_mode_rd: assert property (p_mask_mode_rd) else $error("flag raised in mask mode read");

    property p_pin_reset;
        !$past(q.rstn_s2) |-> (q.state == dcp_pkg::ST_IDLE && !q.dq_oe && !q.collecting);
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("channel alive under die reset");

    property p_scan_low;
        ($past(!i_scan_enable, 1) && $past(!i_scan_enable, 2)) |-> !o_scan_active;
    endproperty
    a_scan_low: assert property (p_scan_low) else $error("scan active with enable low");

    property p_col_aligned;
        (q.cmd_valid && q.cmd_op != dcp_pkg::OP_ACT) |-> (q.col[1:0] == 2'h0);
    endproperty
    a_col_aligned: assert property (p_col_aligned) else $error("column not on burst boundary");

    property p_capture_on_edge;
        (q.slot_cnt != $past(q.slot_cnt) && q.slot_cnt != 2'h0) |-> $past(link_edge);
    endproperty
    a_capture_on_edge: assert property (p_capture_on_edge) else $error("command taken off clock edge");

    property p_gate_off;
        !q.cke_s2 |-> ##1 (!q.dq_oe && !q.dqs_oe && !q.mli_oe);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("driving with clock gate low");

    property p_release;
        (q.state != dcp_pkg::ST_RD_BURST) |-> (!q.dq_oe && !q.dqs_oe && !q.mli_oe);
    endproperty
    a_release: assert property (p_release) else $error("lines driven outside read burst");

    property p_burst_len;
        @(posedge i_mclk) disable iff (i_sys_rst || !q.cke_s2 || !q.rstn_s2)
        $rose(q.dq_oe) |-> ##63 q.dq_oe ##1 !q.dq_oe;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("read burst not sixteen beats");

    c_read_burst: cover property ($fell(q.dq_oe));
    c_write_done: cover property (q.wr_valid);
    c_inverted:   cover property (beat_start && q.mli_out != 2'h0);
    c_activate:   cover property (q.cmd_valid && q.cmd_op == dcp_pkg::OP_ACT);
endmodule // dcp_channel

//--- rtl/dcp_pkg.sv
// Shared constants and types for the DRAM channel pin and addressing block.
package dcp_pkg;
    // Bus and array geometry.
    localparam int CA_W      = 6;
    localparam int DQ_W      = 16;
    localparam int LANES     = 2;
    localparam int BYTE_W    = 8;
    localparam int BANK_W    = 3;
    localparam int ROW_W     = 14;
    localparam int COL_W     = 10;
    localparam int COL_ZERO  = 2;
    localparam int PREFETCH  = 256;
    localparam int BEATS     = PREFETCH / DQ_W;
    localparam int MASK_W    = BEATS * LANES;
    localparam int BEAT_W    = 5;

    // Command word: four command bus samples, first sample in the top bits.
    localparam int WORD_W    = 4 * CA_W;
    localparam int HOLD_W    = 3 * CA_W;
    localparam int OP_LSB    = 22;
    localparam int BANK_LSB  = 19;
    localparam int ROW_LSB   = 5;
    localparam int COLHI_LSB = 11;
    localparam logic [1:0] SLOT_LAST = 2'h3;
    localparam logic [1:0] OP_NOP    = 2'h0;
    localparam logic [1:0] OP_ACT    = 2'h1;
    localparam logic [1:0] OP_RD     = 2'h2;
    localparam logic [1:0] OP_WR     = 2'h3;

    // Termination configuration fields.
    localparam int CFG_W       = 8;
    localparam int TERM_CA_LSB = 4;
    localparam int TERM_CA_W   = 3;
    localparam int EXT_CK_BIT  = 3;
    localparam int EXT_CS_BIT  = 4;

    // Timing: one data beat is half a link clock period.
    localparam int MCLK_NS  = 20;
    localparam int BEAT_NS  = 80;
    localparam int BEAT_CYC = (BEAT_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int TICK_W   = 3;
    localparam logic [TICK_W-1:0] BEAT_TOP = TICK_W'(BEAT_CYC - 1);
    localparam logic [TICK_W-1:0] TICK_RST = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD_LOAD,
        ST_RD_BURST,
        ST_WR_CAPT
    } dcp_state_type;
endpackage

//--- tb/dcp_ctrl_model.sv
// Controller model: frames commands onto the link clock, chip select and command bus.
`timescale 1ns/10ps
module dcp_ctrl_model (
    input  wire logic       i_clk,
    output logic            o_ck_t,
    output logic            o_ck_c,
    output logic            o_cs,
    output logic [5:0]      o_ca,
    output logic [15:0]     o_dq,
    output logic [1:0]      o_dqs_t,
    output logic [1:0]      o_dqs_c,
    output logic [1:0]      o_mask_invert_line
);
    initial begin
        o_ck_t             = 1'b0;
        o_ck_c             = 1'b1;
        o_cs               = 1'b0;
        o_ca               = 6'h2A;
        o_dq               = 16'h0000;
        o_dqs_t            = 2'h0;
        o_dqs_c            = 2'h3;
        o_mask_invert_line = 2'h0;
    end

    // Data leads each strobe edge by two cycles and stays two more, so the sampled beat is settled.
    task automatic burst(input logic [255:0] w, input logic [31:0] f);
        for (int k = 0; k < 16; k++) begin
            o_dq               <= w[16*k +: 16];
            o_mask_invert_line <= f[2*k +: 2];
            repeat (2) @(posedge i_clk);
            o_dqs_t <= {2{~k[0]}};
            o_dqs_c <= {2{k[0]}};
            repeat (2) @(posedge i_clk);
        end
    endtask

    // The link clock stands still between frames, so no stray edge is ever counted.
    task automatic send(input logic [23:0] w);
        for (int k = 0; k < 4; k++) begin
            o_cs <= (k == 0);
            o_ca <= w[23-6*k -: 6];
            repeat (4) @(posedge i_clk);
            o_ck_t <= 1'b1;
            o_ck_c <= 1'b0;
            repeat (4) @(posedge i_clk);
            o_ck_t <= 1'b0;
            o_ck_c <= 1'b1;
        end
        o_cs <= 1'b0;
        o_ca <= ~o_ca;
    endtask
endmodule // dcp_ctrl_model

//--- tb/tb_top.sv
// Self-checking bench for the DRAM channel pin block.
`timescale 1ns/10ps
module tb_top;
    logic i_mclk = 0, i_sys_rst = 1, scan = 0, tpin = 0, inv = 0, mm = 0, rst_n = 1, gate = 1;
    logic [7:0] cfg = 0, ext = 0;
    logic [15:0] dq, o_dq;
    logic [255:0] arr = 0, wd, wdat;
    logic [287:0] e;
    logic [31:0] seed = 32'h3565, a, wf, wmsk;
    logic [5:0] ca;
    logic [1:0] op, dqs_t, dqs_c, flag, mdqs_t, mdqs_c, mfl;
    logic [2:0] bank, tc;
    logic [13:0] row;
    logic [9:0] col;
    logic ck_t, ck_c, cs, dq_oe, dqs_oe, f_oe, cv, cst, ckt, sa, wv;
    int failures = 0, checks_done = 0;

    always #10 i_mclk = ~i_mclk;

    dcp_ctrl_model ctrl_i (.i_clk(i_mclk), .o_ck_t(ck_t), .o_ck_c(ck_c), .o_cs(cs), .o_ca(ca),
        .o_dq(dq), .o_dqs_t(mdqs_t), .o_dqs_c(mdqs_c), .o_mask_invert_line(mfl));
    dcp_channel dcp_channel_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reset_pin_n(rst_n),
        .i_clock_true(ck_t), .i_clock_complement(ck_c), .i_clock_gate(gate), .i_chip_select(cs),
        .i_command_address_bus(ca), .i_cmd_termination_pin(tpin), .i_scan_enable(scan),
        .i_termination_mode_cfg(cfg), .i_termination_mode_cfg_ext(ext), .i_inversion_en(inv),
        .i_mask_mode(mm), .i_array_rd_data(arr), .i_dq(dq), .o_dq(o_dq), .o_dq_oe(dq_oe),
        .i_dqs_t(mdqs_t), .i_dqs_c(mdqs_c), .o_dqs_t(dqs_t), .o_dqs_c(dqs_c), .o_dqs_oe(dqs_oe),
        .i_mask_invert_line(mfl), .o_mask_invert_line(flag), .o_mask_invert_oe(f_oe),
        .o_cmd_valid(cv), .o_cmd_op(op), .o_bank_select_bits(bank), .o_row_select_bits(row),
        .o_column_select_bits(col), .o_wr_valid(wv), .o_wr_data(wdat), .o_wr_mask(wmsk), .o_ca_term_code(tc),
        .o_cs_term_en(cst), .o_ck_term_en(ckt), .o_scan_active(sa));

    function automatic logic [31:0] nx();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [8:0] enc(input logic [7:0] b);
        return (inv && !mm && $countones(b) > 4) ? {1'b1, ~b} : {1'b0, b};
    endfunction

    // Write side: a flag undoes inversion outside mask mode and is the byte mask inside it.
    function automatic logic [287:0] wexp(input logic [255:0] w, input logic [31:0] f);
        for (int j = 0; j < 32; j++) begin
            w[8*j +: 8] ^= {8{inv && !mm && f[j]}};
            f[j] &= mm;
        end
        return {f, w};
    endfunction

    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask

    task automatic wt(input int s);
        for (int i = 0; i < 100; i++) begin
            @(posedge i_mclk);
            #1;
            if ((s == 0 ? cv : s == 1 ? dq_oe : wv) === 1'b1) return;
        end
        failures++;
        test_done();
    endtask

    // Reads follow the burst beat by beat and then expect every pin released.
    task automatic cmd(input logic [23:0] w, input bit rd);
        logic [8:0] x, y;
        fork
            ctrl_i.send(w);
            begin
                wt(0);
                chk("op", w[23:22], op);
                if (rd) begin
                    chk("col", {w[18:11], 2'h0}, col);
                    wt(1);
                    for (int k = 0; k < 16; k++) begin
                        x = enc(arr[16*k+8 +: 8]);
                        y = enc(arr[16*k +: 8]);
                        chk("dq", {x[7:0], y[7:0]}, o_dq);
                        chk("flag", {x[8], y[8]}, flag);
                        chk("dqs", {{2{~k[0]}}, {2{k[0]}}}, {dqs_t, dqs_c});
                        repeat (4) @(posedge i_mclk);
                        #1;
                    end
                    chk("oe", 3'h0, {dq_oe, dqs_oe, f_oe});
                end
            end
        join
    endtask

    initial begin
        repeat (12) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_mclk);
        for (int m = 0; m < 3; m++) begin
            a = nx();
            inv <= (m != 1);
            mm <= (m == 2);
            scan <= a[0];
            tpin <= a[1];
            cfg <= a[15:8];
            ext <= a[23:16];
            for (int i = 0; i < 8; i++) arr[32*i +: 32] <= nx();
            a = nx();
            cmd({2'h1, a[2:0], a[16:3], 5'h0}, 0);
            chk("bank", a[2:0], bank);
            chk("row", a[16:3], row);
            chk("term", {cfg[6:4], ext[4], ext[3]}, {tc, cst, ckt});
            chk("scan", scan, sa);
            cmd({2'h2, a[19:17], a[27:20], 11'h0}, 1);
            for (int i = 0; i < 8; i++) wd[32*i +: 32] = nx();
            wf = nx();
            cmd({2'h3, a[19:17], a[27:20], 11'h0}, 0);
            ctrl_i.burst(wd, wf);
            wt(2);
            e = wexp(wd, wf);
            for (int j = 0; j < 8; j++) chk("wdata", e[32*j +: 32], wdat[32*j +: 32]);
            chk("wmask", e[287:256], wmsk);
        end
        // A die reset, then a low clock gate, each cut a read burst short; a gated frame is lost.
        for (int r = 0; r < 2; r++) begin
            fork
                ctrl_i.send({2'h2, 22'h0});
                wt(1);
            join
            rst_n <= (r != 0);
            gate <= (r == 0);
            repeat (4) @(posedge i_mclk);
            #1;
            chk("cut", 3'h0, {dq_oe, dqs_oe, f_oe});
            if (r == 1) ctrl_i.send({2'h1, 3'h0, ~a[16:3], 5'h0});
            rst_n <= 1'b1;
            gate <= 1'b1;
            repeat (4) @(posedge i_mclk);
        end
        #1;
        chk("gated row", a[16:3], row);
        test_done();
    end
endmodule // tb_top
